// ---- hw/fpc_regs.vh ----
// Register map, field positions, codes and timing counts of the flash poll controller
`ifndef FPC_REGS_VH
`define FPC_REGS_VH

`define FPC_OFF_CTRL      8'h00
`define FPC_OFF_ADDR      8'h04
`define FPC_OFF_WDATA     8'h08
`define FPC_OFF_STATUS    8'h0c

`define FPC_CTRL_GO       0
`define FPC_CTRL_OP_LSB   1
`define FPC_CTRL_OP_MSB   2
`define FPC_CTRL_ABORT    3

`define FPC_OP_WRITE      2'h0
`define FPC_OP_READ       2'h1
`define FPC_OP_POLL       2'h2
`define FPC_OP_RESET      2'h3

`define FPC_ST_BUSY       0
`define FPC_ST_DONE       1
`define FPC_ST_FAIL       2
`define FPC_ST_TIMER      3
`define FPC_ST_TOG2       4
`define FPC_ST_DATA_LSB   8
`define FPC_ST_DATA_MSB   15

`define FPC_ADDR_RST      19'h00000
`define FPC_WDATA_RST     8'h00
`define FPC_RESET_CMD     8'hf0

`define FPC_BIT_POLL      7
`define FPC_BIT_TOG1      6
`define FPC_BIT_LIMIT     5
`define FPC_BIT_TIMER     3
`define FPC_BIT_TOG2      2

`define FPC_CLK_NS        20
`define FPC_TRC_NS        90
`define FPC_TWP_NS        45
`define FPC_TOEH_NS       10
`define FPC_TRC_CYC       ((`FPC_TRC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_TWP_CYC       ((`FPC_TWP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_GAP_CYC       ((`FPC_TOEH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_SYNC_CYC      2

`endif

// ---- hw/fpc_cycle.v ----
// Single flash bus cycle engine: one read or one write on the parallel pins
`include "fpc_regs.vh"

module fpc_cycle (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        start,
	input  wire        wr,
	input  wire [18:0] addr,
	input  wire [7:0]  wdata,
	output reg         done,
	output reg  [7:0]  rdata,
	output reg  [18:0] fl_addr,
	output reg         fl_ce_n,
	output reg         fl_oe_n,
	output reg         fl_we_n,
	output reg  [7:0]  fl_dq_o,
	output reg         fl_dq_oe,
	input  wire [7:0]  fl_dq_i
);
	localparam S_IDLE = 4'b0001;
	localparam S_ACT  = 4'b0010;
	localparam S_HOLD = 4'b0100;
	localparam S_GAP  = 4'b1000;
	localparam integer RD_N  = `FPC_TRC_CYC + `FPC_SYNC_CYC;
	localparam integer WR_N  = `FPC_TWP_CYC;
	localparam integer GAP_N = `FPC_GAP_CYC;
	localparam [3:0] RD_CYC  = RD_N[3:0];
	localparam [3:0] WR_CYC  = WR_N[3:0];
	localparam [3:0] GAP_CYC = GAP_N[3:0];

	reg [3:0] st_q;
	reg [3:0] cnt_q;
	reg       wr_q;
	reg [7:0] sync1_q;
	reg [7:0] sync2_q;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end
		else
		begin
			sync1_q <= fl_dq_i;
			sync2_q <= sync1_q;
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q     <= S_IDLE;
			cnt_q    <= 4'h0;
			wr_q     <= 1'b0;
			done     <= 1'b0;
			rdata    <= 8'h00;
			fl_addr  <= 19'h00000;
			fl_ce_n  <= 1'b1;
			fl_oe_n  <= 1'b1;
			fl_we_n  <= 1'b1;
			fl_dq_o  <= 8'h00;
			fl_dq_oe <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					if (start)
					begin
						wr_q     <= wr;
						fl_addr  <= addr;
						fl_dq_o  <= wdata;
						fl_dq_oe <= wr;
						fl_ce_n  <= 1'b0;
						fl_oe_n  <= wr;
						fl_we_n  <= !wr;
						cnt_q    <= wr ? WR_CYC : RD_CYC;
						st_q     <= S_ACT;
					end
				end
				S_ACT:
				begin
					if (cnt_q == 4'h1)
					begin
						// Data seen through the synchroniser after the access time
						if (!wr_q)
							rdata <= sync2_q;
						fl_ce_n <= 1'b1;
						fl_oe_n <= 1'b1;
						fl_we_n <= 1'b1;
						st_q    <= S_HOLD;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				S_HOLD:
				begin
					// Write data held one cycle past the write enable
					fl_dq_oe <= 1'b0;
					cnt_q    <= GAP_CYC;
					st_q     <= S_GAP;
				end
				S_GAP:
				begin
					if (cnt_q == 4'h1)
					begin
						done <= 1'b1;
						st_q <= S_IDLE;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end
endmodule // fpc_cycle

// ---- hw/fpc_top.v ----
// Flash poll controller: AHB-Lite registers and toggle status polling of a parallel flash
//
// How it works
// RULE1: Device toggles status bit while algorithm runs.
// RULE2: All-protected erase toggles about 100 us.
// RULE3: Protected program toggles about 2 us.
// RULE4: Partially protected erase skips protected sectors.
// RULE5: Erase suspend stops first toggle bit.
// RULE6: Suspend-program toggles until program finishes.
// RULE7: Toggle bit valid from last write pulse.
// RULE8: Second toggle bit marks erasing sectors.
// RULE9: Host compares two consecutive reads' toggle bit.
// RULE10: Toggling plus limit flag: recheck, then reset.
// RULE11: Resumed polling restarts from first double read.
// RULE12: Device raises limit flag on overrun.
// RULE13: Programming zero to one fails via limit.
// RULE14: Host writes reset command after failure.
// RULE15: Window timer bit zero, then one.
// RULE16: Host ignores timer only if fast.
// RULE17: After window, only suspend is accepted.
// RULE18: Host checks timer before and after commands.
// RULE19: Polling bit complements programmed bit seven.
// RULE20: Polling bit zero while erasing.
// RULE21: Non-suspended sector reads return array data.
`include "fpc_regs.vh"

module fpc_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	output wire [18:0] fl_addr,
	output wire        fl_ce_n,
	output wire        fl_oe_n,
	output wire        fl_we_n,
	output wire [7:0]  fl_dq_o,
	output wire        fl_dq_oe,
	input  wire [7:0]  fl_dq_i
);
	localparam ST_IDLE = 2'b01;
	localparam ST_CYC  = 2'b10;

	reg  [1:0]  st_q;
	reg  [1:0]  op_q;
	reg  [1:0]  step_q;
	reg  [7:0]  first_q;
	reg  [18:0] addr_q;
	reg  [7:0]  wdata_q;
	reg         busy_q;
	reg         done_q;
	reg         fail_q;
	reg         timer_q;
	reg         tog2_q;
	reg  [7:0]  last_q;
	reg         abort_q;
	reg         cyc_start_q;
	reg         cyc_wr_q;
	reg  [18:0] cyc_addr_q;
	reg  [7:0]  cyc_wdata_q;
	reg         dp_sel_q;
	reg         dp_wr_q;
	reg  [7:0]  dp_off_q;
	wire        cyc_done;
	wire [7:0]  cyc_rdata;
	wire        wr_ctrl;
	wire        go;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_ctrl   = dp_sel_q && dp_wr_q && (dp_off_q == `FPC_OFF_CTRL);
	assign go        = wr_ctrl && hwdata[`FPC_CTRL_GO] && !busy_q;

	// Address phase capture and registered read data
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_sel_q <= 1'b0;
			dp_wr_q  <= 1'b0;
			dp_off_q <= 8'h00;
			hrdata   <= 32'h00000000;
		end
		else if (hready)
		begin
			dp_sel_q <= hsel && htrans[1];
			dp_wr_q  <= hwrite;
			dp_off_q <= {haddr[7:2], 2'b00};
			hrdata   <= 32'h00000000;
			if (hsel && htrans[1] && !hwrite)
			begin
				case ({haddr[7:2], 2'b00})
					`FPC_OFF_ADDR:   hrdata <= {13'h0000, addr_q};
					`FPC_OFF_WDATA:  hrdata <= {24'h000000, wdata_q};
					`FPC_OFF_STATUS: hrdata <= {16'h0000, last_q, 3'h0, tog2_q,
						timer_q, fail_q, done_q, busy_q};
					default:         hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Software written settings
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q  <= `FPC_ADDR_RST;
			wdata_q <= `FPC_WDATA_RST;
		end
		else if (dp_sel_q && dp_wr_q)
		begin
			if (dp_off_q == `FPC_OFF_ADDR)
				addr_q <= hwdata[18:0];
			if (dp_off_q == `FPC_OFF_WDATA)
				wdata_q <= hwdata[7:0];
		end
	end

	// Operation sequencer and toggle polling
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q        <= ST_IDLE;
			op_q        <= `FPC_OP_WRITE;
			step_q      <= 2'h0;
			first_q     <= 8'h00;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			fail_q      <= 1'b0;
			timer_q     <= 1'b0;
			tog2_q      <= 1'b0;
			last_q      <= 8'h00;
			abort_q     <= 1'b0;
			cyc_start_q <= 1'b0;
			cyc_wr_q    <= 1'b0;
			cyc_addr_q  <= 19'h00000;
			cyc_wdata_q <= 8'h00;
		end
		else
		begin
			cyc_start_q <= 1'b0;
			if (wr_ctrl && hwdata[`FPC_CTRL_ABORT] && busy_q)
				abort_q <= 1'b1;
			case (st_q)
				ST_IDLE:
				begin
					if (go)
					begin
						op_q        <= hwdata[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB];
						step_q      <= 2'h0; // [RULE11]
						busy_q      <= 1'b1;
						done_q      <= 1'b0;
						fail_q      <= 1'b0;
						abort_q     <= 1'b0;
						cyc_start_q <= 1'b1;
						cyc_addr_q  <= addr_q;
						case (hwdata[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB])
							`FPC_OP_WRITE:
							begin
								cyc_wr_q    <= 1'b1;
								cyc_wdata_q <= wdata_q;
							end
							`FPC_OP_RESET:
							begin
								cyc_wr_q    <= 1'b1;
								cyc_wdata_q <= `FPC_RESET_CMD;
							end
							default:
								cyc_wr_q <= 1'b0;
						endcase
						st_q <= ST_CYC;
					end
				end
				ST_CYC:
				begin
					if (cyc_done)
					begin
						if (!cyc_wr_q)
						begin
							last_q  <= cyc_rdata;
							timer_q <= cyc_rdata[`FPC_BIT_TIMER]; // [RULE16] [RULE18]
						end
						if (op_q != `FPC_OP_POLL || cyc_wr_q)
						begin
							busy_q <= 1'b0;
							done_q <= 1'b1;
							st_q   <= ST_IDLE;
						end
						else if (step_q == 2'h0 || step_q == 2'h2)
						begin
							first_q     <= cyc_rdata;
							step_q      <= step_q + 2'h1;
							cyc_start_q <= 1'b1;
						end
						else if (cyc_rdata[`FPC_BIT_TOG1] == first_q[`FPC_BIT_TOG1])
						begin
							// Toggle bit steady: operation finished [RULE9]
							busy_q <= 1'b0;
							done_q <= 1'b1;
							st_q   <= ST_IDLE;
						end
						else if (step_q == 2'h1)
						begin
							tog2_q <= cyc_rdata[`FPC_BIT_TOG2] ^ first_q[`FPC_BIT_TOG2];
							if (abort_q)
							begin
								busy_q <= 1'b0;
								st_q   <= ST_IDLE;
							end
							else
							begin
								// Limit flag seen: recheck pair, else fresh pair [RULE10]
								step_q      <= cyc_rdata[`FPC_BIT_LIMIT] ? 2'h2 : 2'h0;
								cyc_start_q <= 1'b1;
							end
						end
						else
						begin
							// Still toggling after limit: failed, send reset [RULE10] [RULE14]
							fail_q      <= 1'b1;
							cyc_wr_q    <= 1'b1;
							cyc_wdata_q <= `FPC_RESET_CMD;
							cyc_start_q <= 1'b1;
						end
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	fpc_cycle u_cycle (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.start    (cyc_start_q),
		.wr       (cyc_wr_q),
		.addr     (cyc_addr_q),
		.wdata    (cyc_wdata_q),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.fl_addr  (fl_addr),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe),
		.fl_dq_i  (fl_dq_i)
	);
endmodule // fpc_top

// ---- dv/fpc_top_chk.sv ----
// Checker of bus and flash pin timing of the flash poll controller
module fpc_top_chk (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire fl_ce_n,
	input wire fl_oe_n,
	input wire fl_we_n,
	input wire fl_dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_RD_WIDTH: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*7] ##1 fl_oe_n)
		else $error("read strobe width wrong");
	AST_RD_GAP: assert property ($rose(fl_oe_n) |-> fl_oe_n [*2])
		else $error("read gap too short");
	AST_WR_WIDTH: assert property ($fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n)
		else $error("write strobe width wrong");
	AST_NO_CONTEND: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n && fl_we_n)
		else $error("controller drives during read");
	AST_WR_HOLD: assert property ($rose(fl_we_n) |-> fl_dq_oe && fl_ce_n)
		else $error("write data released early");
	AST_BUS_OK: assert property (hreadyout && !hresp)
		else $error("bus response not okay");
	cover property ($fell(fl_oe_n));
	cover property ($fell(fl_we_n));
	cover property ($rose(fl_oe_n) ##4 $fell(fl_oe_n));
endmodule // fpc_top_chk

// ---- dv/fpc_flash_model.sv ----
// Behavioural flash that answers reads with toggle status
module fpc_flash_model (
	input  wire [18:0] fl_addr,
	input  wire        fl_ce_n,
	input  wire        fl_oe_n,
	input  wire        fl_we_n,
	input  wire [7:0]  fl_dq_o,
	input  wire        fl_dq_oe,
	output wire [7:0]  fl_dq_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam [7:0] RESET_CMD   = 8'hf0;
	localparam [7:0] SUSPEND_CMD = 8'hb0;
	integer    busy_n = 0;
	reg        t1 = 1'b0;
	reg        t2 = 1'b0;
	reg        lim = 1'b0;
	reg        tmr = 1'b0;
	reg        ers = 1'b0;
	reg        susp = 1'b0;
	reg        pgm = 1'b0;
	reg        prot = 1'b0;
	reg [7:0]  arr = 8'h00;
	reg [7:0]  last = 8'h00;
	reg [7:0]  wd = 8'h00;
	reg [18:0] ra = 19'h00000;
	reg [18:0] wa = 19'h00000;
	wire       rd = !fl_ce_n && !fl_oe_n;
	wire       dp = ers ? susp : ~wd[7];
	wire [7:0] st = {dp, t1, lim, 1'b0, tmr, t2, 2'b00};
	wire [7:0] v = (busy_n != 0) ? st : arr;
	// Released bus shows inverse of last value
	assign fl_dq_i = rd ? v : ~last;
	always @(negedge fl_oe_n)
		ra = fl_addr;
	always @(posedge fl_oe_n)
	begin
		last = v;
		// Suspend freezes the first toggle bit unless a program runs
		if (busy_n != 0 && (!susp || pgm))
			t1 = ~t1;
		if (busy_n != 0 && ers)
			t2 = ~t2;
		if (busy_n != 0 && (!susp || pgm))
		begin
			busy_n = busy_n - 1;
			if (busy_n == 0 && ers)
			begin
				arr = prot ? arr : 8'hff;
				ers = 1'b0;
			end
		end
	end
	always @(posedge fl_we_n)
	begin
		wa = fl_addr;
		// Running erase with its timer bit set takes nothing but suspend
		if (fl_dq_oe && (!(ers && tmr) || fl_dq_o == SUSPEND_CMD))
		begin
			wd = fl_dq_o;
			if (fl_dq_o == RESET_CMD)
			begin
				busy_n = 0;
				lim = 1'b0;
				ers = 1'b0;
				susp = 1'b0;
			end
			else if (fl_dq_o == SUSPEND_CMD)
				susp = 1'b1;
			else if ((fl_dq_o & ~arr) != 8'h00)
				lim = 1'b1;
		end
	end
endmodule // fpc_flash_model

// ---- dv/tb_fpc_top.sv ----
// Testbench of the flash poll controller over AHB-Lite
`include "fpc_regs.vh"
module tb_fpc_top;
	timeunit 1ns;
	timeprecision 1ns;
	reg         hclk = 1'b0;
	reg         hresetn = 1'b0;
	reg  [31:0] haddr = 32'h0;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0;
	wire        hready;
	wire        hresp;
	wire [31:0] hrdata;
	wire [18:0] fl_addr;
	wire        fl_ce_n;
	wire        fl_oe_n;
	wire        fl_we_n;
	wire        fl_dq_oe;
	wire [7:0]  fl_dq_o;
	wire [7:0]  fl_dq_i;
	integer     bad_count = 0;
	integer     n_checks = 0;
	reg  [31:0] q;
	reg  [7:0]  k;
	fpc_top DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .fl_addr, .fl_ce_n,
		.fl_oe_n, .fl_we_n, .fl_dq_o, .fl_dq_oe, .fl_dq_i);
	fpc_flash_model m (.fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_o, .fl_dq_oe, .fl_dq_i);
	initial
	begin
		forever #10 hclk = ~hclk;
	end
	task give_verdict;
	begin
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task chk(input [31:0] s, input [31:0] e);
	begin
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t %h %h", $time, s, e);
		end
	end
	endtask
	task hwait;
		integer i;
	begin
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && i < 20)
		begin
			@(posedge hclk);
			i = i + 1;
		end
		if (i >= 20)
		begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	endtask
	task xf(input w, input [7:0] a, input [31:0] d);
	begin
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hwait;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
		q = hrdata;
	end
	endtask
	task stat_wait;
		integer i;
	begin
		i = 0;
		q = 32'h1;
		while (q[0] !== 1'b0 && i < 300)
		begin
			xf(1'b0, `FPC_OFF_STATUS, 32'h0);
			i = i + 1;
		end
		if (q[0] !== 1'b0)
		begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	endtask
	task run(input [1:0] op);
	begin
		xf(1'b1, `FPC_OFF_CTRL, {29'h0, op, 1'b1});
		stat_wait;
	end
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (k = 8'h00; k <= 8'h10; k = k + 8'h04)
		begin
			xf(1'b0, k, 32'h0);
			chk(q, 32'h0);
		end
		xf(1'b1, 8'h10, 32'hffffffff);
		xf(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		xf(1'b1, `FPC_OFF_ADDR, 32'hfff7ffff);
		xf(1'b0, `FPC_OFF_ADDR, 32'h0);
		chk(q, 32'h7ffff);
		m.arr = 8'h5a;
		run(`FPC_OP_READ);
		chk(q[15:8], 8'h5a);
		chk(m.ra, 19'h7ffff);
		xf(1'b1, `FPC_OFF_ADDR, 32'h00555);
		xf(1'b1, `FPC_OFF_WDATA, 32'h18);
		run(`FPC_OP_WRITE);
		chk({m.wa, m.wd, q[2:0]}, {19'h00555, 8'h18, 3'b010});
		m.busy_n = 3;
		run(`FPC_OP_POLL);
		chk({m.busy_n[3:0], q[2:0]}, {4'h0, 3'b010});
		m.busy_n = 100000;
		m.tmr = 1'b1;
		xf(1'b1, `FPC_OFF_WDATA, 32'ha5);
		run(`FPC_OP_WRITE);
		run(`FPC_OP_POLL);
		chk(q[4:0], 5'h0e);
		chk(m.wd, 8'hf0);
		run(`FPC_OP_READ);
		chk({q[15:8], q[2:0]}, {8'h5a, 3'b010});
		m.busy_n = 100000;
		m.tmr = 1'b0;
		xf(1'b1, `FPC_OFF_CTRL, {29'h0, `FPC_OP_POLL, 1'b1});
		xf(1'b1, `FPC_OFF_CTRL, 32'h8);
		stat_wait;
		chk(q[1:0], 2'b00);
		m.busy_n = 0;
		run(`FPC_OP_POLL);
		chk(q[2:0], 3'b010);
		m.busy_n = 100000;
		run(`FPC_OP_RESET);
		chk({m.wd, q[2:0]}, {8'hf0, 3'b010});
		run(`FPC_OP_READ);
		chk(q[15:8], 8'h5a);
		m.t1 = 1'b0;
		m.t2 = 1'b0;
		m.tmr = 1'b1;
		m.ers = 1'b1;
		m.busy_n = 4;
		run(`FPC_OP_READ);
		chk(q[15:8], 8'h08);
		run(`FPC_OP_POLL);
		chk({q[15:8], q[4:0]}, {8'hff, 5'h1a});
		give_verdict;
	end
endmodule // tb_fpc_top
bind fpc_top fpc_top_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .fl_ce_n, .fl_oe_n,
	.fl_we_n, .fl_dq_oe);
